// ==== rtl/octreg_pkg.sv ====
// Purpose: shared constants and types for the octal holding register
// Assumes: one clock at 10 MHz, all inputs synchronous to it
// Notes: constants and types only, no logic
//
// Functional notes
// R1: eight stored bits in D flip-flops on one clock, rising edge capture
// R2: clear_n low forces all stored bits to zero asynchronously, overriding all
// R3: load enable high keeps stored bits unchanged at every clock edge; code loads STORE_RESET instead when rst_in is high
// R4: load enable low, clear high: data inputs copied in on rising edge
// R5: output enable low drives true, non-inverted stored bits onto outputs
// R6: output enable high floats outputs; clear, hold and load carry on
package octreg_pkg;

    // ----------------------------------------
    // widths and values after reset
    // ----------------------------------------
    localparam int unsigned REG_WIDTH = 8;
    localparam logic [REG_WIDTH-1:0] STORE_RESET = 8'h00;
    localparam logic OE_RESET = 1'b0;

    // ----------------------------------------
    // clock and cycle figures
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned LOAD_LATENCY_CYC = 1;
    localparam int unsigned OE_LATENCY_CYC = 1;

    // ----------------------------------------
    // register function last applied
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_CLEAR = 2'b00,
        MODE_HOLD = 2'b01,
        MODE_LOAD = 2'b10,
        MODE_RESET = 2'b11
    } mode_t;

endpackage

// ==== rtl/store_if.sv ====
// Purpose: carrier between the control top and the storage array
// Assumes: single clock domain
// Notes: q is the registered content of the storage array
interface store_if #(
    parameter int unsigned WIDTH = 8
);
    logic [WIDTH-1:0] d;
    logic load_n;
    logic sync_rst;
    logic clear_n;
    logic [WIDTH-1:0] q;

    modport ctrl (
        output d,
        output load_n,
        output sync_rst,
        output clear_n,
        input q
    );

    modport store (
        input d,
        input load_n,
        input sync_rst,
        input clear_n,
        output q
    );
endinterface

// ==== rtl/octreg_store.sv ====
// Purpose: eight-bit storage array with load enable and asynchronous clear
// Assumes: clear_n is a direct asynchronous clear, released synchronously upstream
// Notes: one flip-flop per bit, built by a generate loop
module octreg_store
    import octreg_pkg::*;
#(
    parameter int unsigned WIDTH = REG_WIDTH
) (
    // clock
    input wire logic clk_sys_in,
    // carrier
    store_if.store st
);

    // ----------------------------------------
    // per-bit storage
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic q_ff;
            logic nxt_q;

            always_comb begin
                nxt_q = q_ff; // [R3]
                if (st.sync_rst) begin
                    nxt_q = STORE_RESET[gi];
                end else if (!st.load_n) begin
                    nxt_q = st.d[gi]; // [R4]
                end
            end

            // clear wins over clock, enable and data at any time
            always_ff @(posedge clk_sys_in or negedge st.clear_n) begin // [R1]
                if (!st.clear_n) begin
                    q_ff <= 1'b0; // [R2]
                end else begin
                    q_ff <= nxt_q;
                end
            end

            assign st.q[gi] = q_ff;
        end
    endgenerate

endmodule // octreg_store

// ==== rtl/octreg_top.sv ====
// Purpose: octal D register with load enable, async clear and three-state outputs
// Assumes: inputs synchronous to clk_sys_in; pad logic resolves data and enable
// Notes: output enable is registered, so it follows oe_n_in one edge later
//        helper flops ahead of the assertions feed the checks only
module octreg_top
    import octreg_pkg::*;
#(
    parameter int unsigned WIDTH = REG_WIDTH
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // register controls
    input wire logic clear_n_in,
    input wire logic load_n_in,
    input wire logic oe_n_in,
    // parallel data
    input wire logic [WIDTH-1:0] data_in,
    // three-state outputs
    output logic [WIDTH-1:0] y_data_out,
    output logic y_oe_out,
    // status
    output mode_t mode_out
);

    // ----------------------------------------
    // storage array
    // ----------------------------------------
    store_if #(.WIDTH(WIDTH)) st ();

    assign st.d = data_in;
    assign st.load_n = load_n_in;
    assign st.sync_rst = rst_in;
    assign st.clear_n = clear_n_in;

    octreg_store #(
        .WIDTH(WIDTH)
    ) u_store (
        .clk_sys_in(clk_sys_in),
        .st(st)
    );

    // data pins come straight from the storage flops, never inverted
    assign y_data_out = st.q; // [R5]

    // ----------------------------------------
    // output enable
    // ----------------------------------------
    logic oe_ff;
    logic nxt_oe;

    // enable has no effect on storage, only on the pad drive
    always_comb begin
        nxt_oe = ~oe_n_in; // [R5] [R6]
        if (rst_in) begin
            nxt_oe = OE_RESET;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        oe_ff <= nxt_oe;
    end

    assign y_oe_out = oe_ff;

    // ----------------------------------------
    // function status
    // ----------------------------------------
    mode_t mode_ff;
    mode_t nxt_mode;

    always_comb begin
        nxt_mode = MODE_HOLD;
        case ({clear_n_in, load_n_in})
            2'b00: nxt_mode = MODE_CLEAR;
            2'b01: nxt_mode = MODE_CLEAR;
            2'b10: nxt_mode = MODE_LOAD;
            2'b11: nxt_mode = MODE_HOLD;
            default: nxt_mode = MODE_HOLD;
        endcase
        if (rst_in) begin
            nxt_mode = MODE_RESET;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        mode_ff <= nxt_mode;
    end

    assign mode_out = mode_ff;

    // ----------------------------------------
    // assertion helpers
    // ----------------------------------------
    // a clear pulse between two edges leaves no trace in sampled inputs,
    // so it is remembered until the next rising edge
    logic clear_seen_ff;
    // stored bits at the falling edge, to catch moves away from a rising edge
    logic [WIDTH-1:0] y_fall_ff;

    always_ff @(posedge clk_sys_in or negedge clear_n_in) begin
        if (!clear_n_in) begin
            clear_seen_ff <= 1'b1;
        end else begin
            clear_seen_ff <= 1'b0;
        end
    end

    always_ff @(negedge clk_sys_in) begin
        y_fall_ff <= y_data_out;
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_load_req;
        clear_n_in && !load_n_in && !rst_in;
    endsequence

    sequence s_hold_req;
        clear_n_in && load_n_in && !rst_in;
    endsequence

    sequence s_float_req;
        oe_n_in && !rst_in;
    endsequence

    sequence s_clear_req;
        !clear_n_in && !rst_in;
    endsequence

    // checks that span an edge allow for a clear pulse that fell in between

    AST_CLEAR_ZERO: assert property ( // [R2]
        @(posedge clk_sys_in) !clear_n_in |-> (y_data_out == '0)
    ) else $error("stored bits not zero while clear is low");

    AST_CLEAR_OVERRIDES_LOAD: assert property ( // [R2]
        @(posedge clk_sys_in) disable iff (rst_in)
        (!clear_n_in && !load_n_in && (data_in != '0))[*3] |-> (y_data_out == '0)
    ) else $error("load got through while clear was held");

    AST_HOLD: assert property ( // [R3]
        @(posedge clk_sys_in) disable iff (rst_in)
        s_hold_req |=> (!clear_n_in || rst_in || clear_seen_ff || $stable(y_data_out))
    ) else $error("stored bits changed while load enable high");

    AST_HOLD_RUN: assert property ( // [R3]
        @(posedge clk_sys_in) disable iff (rst_in)
        (s_hold_req ##1 s_hold_req ##1 s_hold_req) |=> (!clear_n_in || rst_in || clear_seen_ff ||
            $past(clear_seen_ff) || $past(clear_seen_ff, 2) || y_data_out == $past(y_data_out, 3))
    ) else $error("stored bits drifted over a hold run");

    AST_LOAD: assert property ( // [R4]
        @(posedge clk_sys_in) disable iff (rst_in)
        s_load_req |=> (!clear_n_in || clear_seen_ff || y_data_out == $past(data_in))
    ) else $error("data inputs not captured on rising edge");

    AST_EDGE_ONLY: assert property ( // [R1]
        @(posedge clk_sys_in) disable iff (rst_in)
        (clear_n_in && !clear_seen_ff) |-> (y_data_out == y_fall_ff)
    ) else $error("stored bits moved away from a rising edge");

    AST_OE_ON: assert property ( // [R5]
        @(posedge clk_sys_in) disable iff (rst_in)
        (!oe_n_in && !rst_in) |=> y_oe_out
    ) else $error("outputs not driven after enable low");

    AST_FLOAT: assert property ( // [R6]
        @(posedge clk_sys_in) disable iff (rst_in)
        s_float_req |=> !y_oe_out
    ) else $error("outputs driven after enable high");

    AST_FLOAT_STILL_LOADS: assert property ( // [R6]
        @(posedge clk_sys_in) disable iff (rst_in)
        (s_float_req and s_load_req) ##1 (oe_n_in && clear_n_in) |-> (clear_seen_ff || y_data_out == $past(data_in))
    ) else $error("load lost while outputs floated");

    AST_RESET_STATE: assert property (
        @(posedge clk_sys_in) rst_in |=> (!y_oe_out && y_data_out == STORE_RESET && mode_out == MODE_RESET)
    ) else $error("reset state not reached one edge after reset");

    AST_MODE_CLEAR: assert property ( // [R2]
        @(posedge clk_sys_in) disable iff (rst_in)
        s_clear_req |=> (mode_out == MODE_CLEAR)
    ) else $error("status not clear after a clear edge");

    AST_CLEAR_RUN_ZERO: assert property ( // [R2]
        @(posedge clk_sys_in) disable iff (rst_in)
        (s_clear_req ##1 s_clear_req ##1 s_clear_req) |=> (y_data_out == '0)
    ) else $error("stored bits not zero after a clear run");

    AST_MODE_HOLD: assert property ( // [R3]
        @(posedge clk_sys_in) disable iff (rst_in)
        s_hold_req |=> (mode_out == MODE_HOLD)
    ) else $error("status not hold after a hold edge");

    AST_MODE_LOAD: assert property ( // [R4]
        @(posedge clk_sys_in) disable iff (rst_in)
        s_load_req |=> (mode_out == MODE_LOAD)
    ) else $error("status not load after a load edge");

    AST_LOAD_TRUE_POLARITY: assert property ( // [R5]
        @(posedge clk_sys_in) disable iff (rst_in)
        (s_load_req and !oe_n_in) |=> (!clear_n_in || clear_seen_ff || (y_oe_out && y_data_out == $past(data_in)))
    ) else $error("driven outputs do not show the loaded bits");

    AST_OE_AFTER_FLOAT: assert property ( // [R5]
        @(posedge clk_sys_in) disable iff (rst_in)
        (s_float_req ##1 (!oe_n_in && !rst_in)) |=> y_oe_out
    ) else $error("outputs not driven again after float");

    AST_FLOAT_STILL_HOLDS: assert property ( // [R6]
        @(posedge clk_sys_in) disable iff (rst_in)
        (s_float_req and s_hold_req) |=> (!clear_n_in || clear_seen_ff || $stable(y_data_out))
    ) else $error("hold lost while outputs floated");

    AST_FLOAT_STILL_CLEARS: assert property ( // [R6]
        @(posedge clk_sys_in) disable iff (rst_in)
        (s_float_req and s_clear_req) |=> (y_data_out == '0)
    ) else $error("clear lost while outputs floated");

    AST_ENABLE_NO_STORE_EFFECT: assert property ( // [R6]
        @(posedge clk_sys_in) disable iff (rst_in)
        (s_hold_req and $changed(oe_n_in)) |=> (!clear_n_in || clear_seen_ff || $stable(y_data_out))
    ) else $error("enable change disturbed the stored bits");

endmodule // octreg_top

// ==== tb/bus_reader_model.sv ====
// Purpose: far-side bus logic that reads the three-state outputs
// Assumes: no pull on the bus lines
// Notes: behavioural; a released bus floats
module bus_reader_model #(
    parameter int unsigned WIDTH = 8
) (
    // from the register
    input wire logic [WIDTH-1:0] y_data_in,
    input wire logic y_oe_in,
    // resolved bus
    output wire logic [WIDTH-1:0] bus_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // no keeper, so no stale value survives a release
    assign bus_out = y_oe_in ? y_data_in : {WIDTH{1'bz}};
endmodule // bus_reader_model

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the octal holding register
// Assumes: inputs change 10 ns after the rising edge
// Notes: output enable seen one edge late, as registered
module tb import octreg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in, rst_in, clear_n_in, load_n_in, oe_n_in;
    logic [REG_WIDTH-1:0] data_in, y_data_out;
    logic y_oe_out;
    mode_t mode_out;
    wire logic [REG_WIDTH-1:0] bus;
    int n_mismatch = 0;
    int checked = 0;
    logic [REG_WIDTH-1:0] vals [5] = '{8'ha5, 8'h5a, 8'hff, 8'h00, 8'h81};

    octreg_top #(.WIDTH(REG_WIDTH)) DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .clear_n_in(clear_n_in), .load_n_in(load_n_in), .oe_n_in(oe_n_in), .data_in(data_in),
        .y_data_out(y_data_out), .y_oe_out(y_oe_out), .mode_out(mode_out));
    bus_reader_model #(.WIDTH(REG_WIDTH)) bus_model (.y_data_in(y_data_out), .y_oe_in(y_oe_out),
        .bus_out(bus));

    initial begin
        clk_sys_in = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;
    end

    task automatic conclude();
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_data(input logic [REG_WIDTH-1:0] got, input logic [REG_WIDTH-1:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t data got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t enable got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk_mode(input mode_t got, input mode_t exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t mode got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic tick();
        @(posedge clk_sys_in);
        #10;
    endtask

    task automatic do_reset();
        rst_in = 1'b1;
        repeat (16) tick();
        chk_data(y_data_out, STORE_RESET);
        chk_bit(y_oe_out, 1'b0);
        chk_mode(mode_out, MODE_RESET);
        rst_in = 1'b0;
    endtask

    // back-to-back loads, read through the enabled bus
    task automatic t_load();
        oe_n_in = 1'b0;
        load_n_in = 1'b0;
        foreach (vals[i]) begin
            data_in = vals[i];
            tick();
            chk_data(y_data_out, vals[i]);
            chk_mode(mode_out, MODE_LOAD);
            chk_data(bus, vals[i]);
        end
    endtask

    // enable goes high with the hold, so the float checks see a floated bus while the bits hold
    task automatic t_hold();
        load_n_in = 1'b1;
        oe_n_in = 1'b1;
        data_in = 8'h3c;
        repeat (4) tick();
        chk_data(y_data_out, 8'h81);
        chk_mode(mode_out, MODE_HOLD);
        chk_bit(y_oe_out, 1'b0);
        chk_data(bus, 8'hzz);
    endtask

    // clear between edges while a load is requested
    task automatic t_clear();
        load_n_in = 1'b0;
        data_in = 8'h77;
        clear_n_in = 1'b0;
        #1;
        chk_data(y_data_out, 8'h00);
        repeat (3) begin
            tick();
            chk_data(y_data_out, 8'h00);
            chk_mode(mode_out, MODE_CLEAR);
        end
        clear_n_in = 1'b1;
        tick();
        chk_data(y_data_out, 8'h77);
    endtask

    // storage keeps working while the outputs float
    task automatic t_float();
        oe_n_in = 1'b1;
        data_in = 8'h42;
        tick();
        chk_bit(y_oe_out, 1'b0);
        chk_data(bus, 8'hzz);
        chk_data(y_data_out, 8'h42);
        clear_n_in = 1'b0;
        #1;
        chk_data(y_data_out, 8'h00);
        clear_n_in = 1'b1;
        oe_n_in = 1'b0;
        tick();
        chk_bit(y_oe_out, 1'b1);
        chk_data(bus, 8'h42);
    endtask

    initial begin
        rst_in = 1'b1;
        clear_n_in = 1'b1;
        load_n_in = 1'b1;
        oe_n_in = 1'b1;
        data_in = 8'h00;
        do_reset();
        t_load();
        t_hold();
        t_clear();
        t_float();
        do_reset();
        conclude();
    end

    // hang guard
    initial begin
        repeat (2000) @(posedge clk_sys_in);
        n_mismatch++;
        conclude();
    end
endmodule // tb
